/* File: rtl/sdcd_decoder.sv */
// Device end: samples command pins each edge and classifies them
`timescale 1ns/1ps
module sdcd_decoder
  import sdcd_pkg::*;
(
  input  wire logic              mclk,          // System clock
  input  wire logic              reset_n,       // Reset, low active
  sdcd_if.dev                    pins,          // Command pins
  output logic [4:0]             cmd_code,      // Decoded command
  output logic                   cmd_valid,     // One cycle per new command
  output logic [BA_W-1:0]        cmd_bank,      // Bank or mode register
  output logic [ADDR_W-1:0]      cmd_addr,      // Row, column or op code
  output logic                   cmd_autoclose, // Close bank after burst
  output logic                   cmd_chop,      // Chopped burst chosen
  output logic                   burst_busy,    // Burst in flight
  output logic                   pdown,         // In power-down
  output logic                   sref,          // In self-refresh
  output logic                   refresh_act,   // Array refresh allowed
  output logic                   term_en        // Termination usable
);
  /////////////////////////////////////////////////////////////////
  // Strobe map used below, as {cs_n, ras_n, cas_n, we_n}:
  //   1xxx  deselect, nothing new starts
  //   0111  idle command, running work carries on
  //   0000  mode register write, ba picks the register
  //   0001  refresh, or self-refresh entry when cke falls and no burst runs
  //   0010  bank close, A10 high closes every bank
  //   0011  open row, row on the address lines
  //   0100  store, A10 auto-close, A12 burst length
  //   0101  read, same address use as store
  //   0110  impedance calibration, A10 picks long or short
  // Clock-enable pairs (previous edge, this edge):
  //   11    ordinary decode of the map above
  //   10    entry into power-down or self-refresh
  //   01    exit back to the active state
  //   00    low-power state held, pins ignored
  // Anything not listed is classed as reserved and starts nothing.
  //
  // Hazards a user must know:
  //   The first edge after reset sees cke low twice and is reserved.
  //   Raising cke after reset is reported as a power-down exit.
  //   A command that lands mid-burst is reported (self-refresh entry is classed reserved), but the burst
  //   counter is not restarted, so the running burst completes.
  //   Self-refresh exit needs only cke high with idle or deselect;
  //   no run of clock edges is needed before it is seen.
  //   Termination control is never looked at by the decode.
  /////////////////////////////////////////////////////////////////
  // Pin view, fixed or on-the-fly burst length
  logic         otf_en_reg;    // On-the-fly length enabled by mode write
  logic         cke_prev_reg;  // Clock enable of previous edge
  logic [3:0]   burst_cnt_reg; // Remaining burst edges
  logic [3:0]   burst_cnt_next;
  sdcd_state_t  state_reg;     // Power state
  sdcd_state_t  state_next;

  wire is_quiet  = pins.cs_n | (pins.ras_n & pins.cas_n & pins.we_n);
  wire sel       = ~pins.cs_n;
  wire hh        = cke_prev_reg & pins.cke;          // Enable high both edges
  wire hl        = cke_prev_reg & ~pins.cke;         // Falling clock enable
  wire lh        = ~cke_prev_reg & pins.cke;         // Rising clock enable
  wire a10       = pins.addr[A10_POS];               // Auto-close or all-banks
  wire a12       = pins.addr[A12_POS];               // Burst length choice
  wire is_mwr    = sel & ~pins.ras_n & ~pins.cas_n & ~pins.we_n;
  wire is_ref    = sel & ~pins.ras_n & ~pins.cas_n & pins.we_n;
  wire is_pre    = sel & ~pins.ras_n & pins.cas_n & ~pins.we_n;
  wire is_row    = sel & ~pins.ras_n & pins.cas_n & pins.we_n;
  wire is_wr     = sel & pins.ras_n & ~pins.cas_n & ~pins.we_n;
  wire is_rd     = sel & pins.ras_n & ~pins.cas_n & pins.we_n;
  wire is_zq     = sel & pins.ras_n & pins.cas_n & ~pins.we_n;
  wire in_active = (state_reg == SDCD_ST_ACTIVE);
  wire chop_sel  = otf_en_reg & ~a12;

  /////////////////////////////////////////////////////////////////
  // Command classification; term_ctl takes no part
  // Low-power states are looked at first, since there the strobes
  // only matter for the exit; then clock-enable edges, and last the
  // full map with clock enable high on both edges.
  logic [4:0] code_sel;
  always_comb begin
    code_sel = SDCD_RESERVED;
    if (state_reg == SDCD_ST_SREF) begin
      // Exit seen on clock enable high with idle or deselect, no free-running clock needed
      code_sel = (pins.cke && is_quiet) ? SDCD_SR_EXIT : SDCD_RESERVED;
    end else if (state_reg == SDCD_ST_PDOWN) begin
      code_sel = (lh && is_quiet) ? SDCD_PD_EXIT : SDCD_RESERVED;
    end else if (hl && is_ref && burst_cnt_reg == 4'h0) begin
      code_sel = SDCD_SR_ENTRY;
    end else if (hl && is_quiet) begin
      code_sel = SDCD_PD_ENTRY;
    end else if (in_active && lh && is_quiet) begin
      // Clock enable raised after reset counts as a power-down exit
      code_sel = SDCD_PD_EXIT;
    end else if (!hh) begin
      code_sel = SDCD_RESERVED;                      // Other edge cases
    end else if (pins.cs_n) begin
      code_sel = SDCD_DESELECT;
    end else if (is_quiet) begin
      code_sel = SDCD_IDLE_CMD;
    end else if (is_mwr) begin
      code_sel = SDCD_MODE_REG_WRITE;
    end else if (is_ref) begin
      code_sel = SDCD_REFRESH;
    end else if (is_pre) begin
      code_sel = a10 ? SDCD_CLOSE_ALL : SDCD_CLOSE_BANK;
    end else if (is_row) begin
      code_sel = SDCD_OPEN_ROW;
    end else if (is_wr) begin
      code_sel = SDCD_STORE;
    end else if (is_rd) begin
      code_sel = SDCD_READ;
    end else if (is_zq) begin
      code_sel = a10 ? SDCD_ZQ_LONG : SDCD_ZQ_SHORT;
    end
  end

  wire starts_burst = (code_sel == SDCD_STORE) || (code_sel == SDCD_READ);
  wire [3:0] burst_len = chop_sel ? 4'(BURST_CHOP) : 4'(BURST_EIGHT);

  /////////////////////////////////////////////////////////////////
  // Burst counter: nothing cuts a running burst short
  // The counter loads only from zero, so a read or store that lands
  // mid-burst is reported but cannot restart or shorten the burst.
  // Counts are in clock edges; chopped bursts take half as many.
  always_comb begin
    burst_cnt_next = burst_cnt_reg;
    if (burst_cnt_reg != 4'h0) begin
      burst_cnt_next = burst_cnt_reg - 4'h1;
    end else if (starts_burst) begin
      burst_cnt_next = burst_len - 4'h1;
    end
  end

  // Power state moves
  // Only entry and exit codes move the state; every other code,
  // reserved ones too, leaves it where it is.
  always_comb begin
    state_next = state_reg;
    case (code_sel)
      SDCD_SR_ENTRY: state_next = SDCD_ST_SREF;
      SDCD_PD_ENTRY: state_next = SDCD_ST_PDOWN;
      SDCD_SR_EXIT,
      SDCD_PD_EXIT:  state_next = SDCD_ST_ACTIVE;
      default:       state_next = state_reg;
    endcase
  end

  /////////////////////////////////////////////////////////////////
  // State registers; reset does not wait for anything
  // Clock enable is remembered low after reset, matching the
  // controller, so no false falling edge follows reset.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg     <= SDCD_ST_ACTIVE;
      cke_prev_reg  <= 1'b0;
      burst_cnt_reg <= 4'h0;
      otf_en_reg    <= 1'b1;
    end else begin
      state_reg     <= state_next;
      cke_prev_reg  <= pins.cke;
      burst_cnt_reg <= burst_cnt_next;
      // Mode register zero picks fixed or on-the-fly length
      if (code_sel == SDCD_MODE_REG_WRITE && pins.ba == '0) begin
        otf_en_reg <= pins.addr[0] & pins.addr[1];
      end
    end
  end

  // Output registers
  // Level flags follow the next power state so that they change on
  // the same edge as the matching cmd_code. The address side outputs
  // hold their last value between commands.
  wire new_cmd = (code_sel != SDCD_RESERVED) && (code_sel != SDCD_DESELECT)
                 && (code_sel != SDCD_IDLE_CMD);
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_code      <= SDCD_DESELECT;
      cmd_valid     <= 1'b0;
      cmd_bank      <= '0;
      cmd_addr      <= '0;
      cmd_autoclose <= 1'b0;
      cmd_chop      <= 1'b0;
      burst_busy    <= 1'b0;
      pdown         <= 1'b0;
      sref          <= 1'b0;
      refresh_act   <= 1'b1;
      term_en       <= 1'b1;
    end else begin
      cmd_code      <= code_sel;
      cmd_valid     <= new_cmd;
      if (new_cmd) begin
        cmd_bank      <= pins.ba;
        cmd_addr      <= pins.addr;
        cmd_autoclose <= starts_burst & a10;
        cmd_chop      <= starts_burst & chop_sel;
      end
      burst_busy    <= (burst_cnt_next != 4'h0);
      pdown         <= (state_next == SDCD_ST_PDOWN);
      sref          <= (state_next == SDCD_ST_SREF);
      refresh_act   <= (state_next != SDCD_ST_PDOWN);
      term_en       <= (state_next != SDCD_ST_SREF);
    end
  end
endmodule

/* File: rtl/sdcd_pkg.sv */
// Shared constants and types of the command decoder and its driver end
package sdcd_pkg;
  localparam int BA_W        = 3;   // Bank lines
  localparam int ADDR_W      = 15;  // Address lines
  localparam int A10_POS     = 10;  // Auto-close / all-banks bit
  localparam int A12_POS     = 12;  // Chop select bit
  localparam int BURST_EIGHT = 4;   // Clock edges of an eight-beat burst
  localparam int BURST_CHOP  = 2;   // Clock edges of a chopped burst
  localparam int CKE_MIN     = 3;   // Least stable clock-enable edges
  localparam logic [4:0] CMD_W = 5'h05; // Width marker of command codes

  // Decoded command kinds
  typedef enum logic [4:0] {
    SDCD_DESELECT      = 5'h00,
    SDCD_IDLE_CMD      = 5'h01,
    SDCD_MODE_REG_WRITE= 5'h02,
    SDCD_REFRESH       = 5'h03,
    SDCD_SR_ENTRY      = 5'h04,
    SDCD_SR_EXIT       = 5'h05,
    SDCD_PD_ENTRY      = 5'h06,
    SDCD_PD_EXIT       = 5'h07,
    SDCD_OPEN_ROW      = 5'h08,
    SDCD_CLOSE_BANK    = 5'h09,
    SDCD_CLOSE_ALL     = 5'h0A,
    SDCD_STORE         = 5'h0B,
    SDCD_READ          = 5'h0C,
    SDCD_ZQ_LONG       = 5'h0D,
    SDCD_ZQ_SHORT      = 5'h0E,
    SDCD_RESERVED      = 5'h0F
  } sdcd_cmd_t;

  // Power state of the decoder, one-hot
  typedef enum logic [2:0] {
    SDCD_ST_ACTIVE = 3'h1,
    SDCD_ST_PDOWN  = 3'h2,
    SDCD_ST_SREF   = 3'h4
  } sdcd_state_t;
endpackage

/* File: rtl/sdcd_if.sv */
// Command and address pins between controller and decoder
`timescale 1ns/1ps
interface sdcd_if;
  import sdcd_pkg::*;
  logic              cs_n;     // Chip select, low active
  logic              ras_n;    // Row strobe, low active
  logic              cas_n;    // Column strobe, low active
  logic              we_n;     // Write strobe, low active
  logic              cke;      // Clock enable
  logic              term_ctl; // Termination control
  logic [BA_W-1:0]   ba;       // Bank lines
  logic [ADDR_W-1:0] addr;     // Address lines
  modport ctrl (output cs_n, ras_n, cas_n, we_n, cke, term_ctl, ba, addr);
  modport dev  (input  cs_n, ras_n, cas_n, we_n, cke, term_ctl, ba, addr);
endinterface

/* File: rtl/sdcd_ctrl.sv */
// Controller end: turns user requests into pin encodings
`timescale 1ns/1ps
module sdcd_ctrl
  import sdcd_pkg::*;
(
  input  wire logic              mclk,      // System clock
  input  wire logic              reset_n,   // Reset, low active
  input  wire logic              req_valid, // Request present
  input  wire logic [4:0]        req_code,  // Command kind wanted
  input  wire logic [BA_W-1:0]   req_bank,  // Bank or mode register
  input  wire logic [ADDR_W-1:0] req_addr,  // Address or op code
  input  wire logic              req_term,  // Termination level
  output logic                   req_ready, // Request taken this edge
  sdcd_if.ctrl                   pins       // Command pins
);
  logic [1:0] cke_hold_reg; // Edges since last clock-enable change
  logic       cke_reg;

  // Holding clock enable stable before another change is allowed
  wire cke_ok  = (cke_hold_reg >= 2'(CKE_MIN - 1));
  wire want_lo = (req_code == SDCD_SR_ENTRY) || (req_code == SDCD_PD_ENTRY);
  wire want_hi = (req_code == SDCD_SR_EXIT) || (req_code == SDCD_PD_EXIT);
  wire cke_chg = (want_lo & cke_reg) | (want_hi & ~cke_reg);
  wire take    = req_valid & (~cke_chg | cke_ok) & (cke_reg | want_hi);

  // A10 carries the all-banks and long-calibration choice
  wire a10_set = (req_code == SDCD_CLOSE_ALL) || (req_code == SDCD_ZQ_LONG);
  wire a10_clr = (req_code == SDCD_CLOSE_BANK) || (req_code == SDCD_ZQ_SHORT);
  wire a10_out = a10_set | (req_addr[A10_POS] & ~a10_clr);
  wire [ADDR_W-1:0] addr_out = {req_addr[ADDR_W-1:A10_POS+1], a10_out, req_addr[A10_POS-1:0]};

  /////////////////////////////////////////////////////////////////
  // Pin registers; idle command whenever nothing is taken
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      // Pins deselected and clock enable low in reset
      pins.cs_n <= 1'b1;
      pins.ras_n <= 1'b1;
      pins.cas_n <= 1'b1;
      pins.we_n <= 1'b1;
      pins.cke <= 1'b0;
      cke_reg <= 1'b0;
      pins.term_ctl <= 1'b0;
      pins.ba <= '0;
      pins.addr <= '0;
      cke_hold_reg <= '0;
      req_ready <= 1'b0;
    end else begin
      req_ready <= take;
      pins.term_ctl <= req_term;
      pins.ba <= req_bank;
      pins.addr <= addr_out;
      if (take && cke_chg) begin
        cke_reg <= ~cke_reg;
        pins.cke <= ~cke_reg;
        cke_hold_reg <= '0;
      end else if (!cke_ok) begin
        cke_hold_reg <= cke_hold_reg + 2'h1;
      end
      {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'h7; // Idle
      if (take) begin
        case (req_code)
          SDCD_DESELECT:       {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'hF;
          SDCD_MODE_REG_WRITE: {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'h0;
          SDCD_REFRESH,
          SDCD_SR_ENTRY:       {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'h1;
          SDCD_OPEN_ROW:       {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'h3;
          SDCD_CLOSE_BANK,
          SDCD_CLOSE_ALL:      {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'h2;
          SDCD_STORE:          {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'h4;
          SDCD_READ:           {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'h5;
          SDCD_ZQ_LONG,
          SDCD_ZQ_SHORT:       {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'h6;
          default:             {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'h7;
        endcase
      end
    end
  end
endmodule

/* File: testbench/sdcd_props.sv */
// Concurrent checks on the command pins and decoded outputs
`timescale 1ns/1ps
module sdcd_props
  import sdcd_pkg::*;
(
  input wire logic              mclk,
  input wire logic              reset_n,
  input wire logic              cs_n,
  input wire logic              ras_n,
  input wire logic              cas_n,
  input wire logic              we_n,
  input wire logic              cke,
  input wire logic [BA_W-1:0]   ba,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [4:0]        cmd_code,
  input wire logic              cmd_valid,
  input wire logic [BA_W-1:0]   cmd_bank,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic              cmd_autoclose,
  input wire logic              cmd_chop,
  input wire logic              pdown,
  input wire logic              sref,
  input wire logic              refresh_act,
  input wire logic              term_en
);
  // Burst length mode as last written to mode register zero
  logic otf_seen_reg;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      otf_seen_reg <= 1'b1;
    end else if (!cs_n && !ras_n && !cas_n && !we_n && cke && $past(cke) && ba == '0) begin
      otf_seen_reg <= (addr[1:0] == 2'h3);
    end
  end
  // One clock domain for every check
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////
  cke_hold_a: assert property ($changed(cke) |=> $stable(cke) [*2])
    else $error("clock enable changed too soon");
  desel_quiet_a: assert property (cs_n && cke && $past(cke)
    |=> !cmd_valid && cmd_code == SDCD_DESELECT) else $error("deselect not quiet");
  idle_quiet_a: assert property (!cs_n && ras_n && cas_n && we_n && cke && $past(cke)
    |=> !cmd_valid && cmd_code == SDCD_IDLE_CMD) else $error("idle not quiet");
  read_decode_a: assert property (!cs_n && ras_n && !cas_n && we_n && cke && $past(cke)
    |=> cmd_valid && cmd_code == SDCD_READ && cmd_bank == $past(ba)
    && cmd_autoclose == $past(addr[A10_POS])) else $error("read decode wrong");
  store_decode_a: assert property (!cs_n && ras_n && !cas_n && !we_n && cke
    && $past(cke) |=> cmd_valid && cmd_code == SDCD_STORE
    && cmd_chop == ($past(otf_seen_reg) && !$past(addr[A12_POS]))
    && cmd_autoclose == $past(addr[A10_POS])) else $error("store decode wrong");
  row_open_a: assert property (!cs_n && !ras_n && cas_n && we_n && cke && $past(cke)
    |=> cmd_code == SDCD_OPEN_ROW && cmd_addr == $past(addr)) else $error("open row wrong");
  bank_close_a: assert property (!cs_n && !ras_n && cas_n && !we_n && cke && $past(cke)
    |=> cmd_code == ($past(addr[A10_POS]) ? SDCD_CLOSE_ALL : SDCD_CLOSE_BANK))
    else $error("bank close wrong");
  mode_write_a: assert property (!cs_n && !ras_n && !cas_n && !we_n && cke && $past(cke)
    |=> cmd_code == SDCD_MODE_REG_WRITE && cmd_bank == $past(ba))
    else $error("mode write wrong");
  zq_cal_a: assert property (!cs_n && ras_n && cas_n && !we_n && cke && $past(cke)
    |=> cmd_code == ($past(addr[A10_POS]) ? SDCD_ZQ_LONG : SDCD_ZQ_SHORT))
    else $error("calibration decode wrong");
  sr_entry_a: assert property ($fell(cke) && !cs_n && !ras_n && !cas_n && we_n
    |=> cmd_code == SDCD_SR_ENTRY) else $error("self-refresh entry missed");
  pd_entry_a: assert property ($fell(cke) && (cs_n || (ras_n && cas_n && we_n))
    |=> cmd_code == SDCD_PD_ENTRY) else $error("power-down entry missed");
  pd_norefresh_a: assert property (pdown |-> !refresh_act)
    else $error("refresh during power-down");
  sref_noterm_a: assert property (sref |-> !term_en)
    else $error("termination in self-refresh");
endmodule

/* File: testbench/tb_top.sv */
// Bench joining controller end to decoder end through the pin interface
`timescale 1ns/1ps
module tb_top;
  import sdcd_pkg::*;
  typedef struct packed {
    logic [4:0]        code; // Requested command
    logic [BA_W-1:0]   bank; // Bank or mode register
    logic [ADDR_W-1:0] addr; // Address or op code
    logic [1:0]        chk;  // Compare address, flags
    logic              ac;   // Expected auto-close
    logic              chop; // Expected chop
  } sdcd_row_t;
  logic              mclk = 1'b0;
  logic              reset_n = 1'b0;
  logic              req_valid = 1'b0;
  logic [4:0]        req_code = 5'h00;
  logic [BA_W-1:0]   req_bank = '0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic              req_term = 1'b0;
  logic              req_ready;
  logic [4:0]        cmd_code;
  logic              cmd_valid, cmd_autoclose, cmd_chop, burst_busy;
  logic              pdown, sref, refresh_act, term_en;
  logic [BA_W-1:0]   cmd_bank;
  logic [ADDR_W-1:0] cmd_addr;
  int                num_errors = 0;
  int                checks_done = 0;
  sdcd_row_t         rows [16];
  sdcd_if pins_if ();
  sdcd_ctrl i_sdcd_ctrl (.mclk(mclk), .reset_n(reset_n), .req_valid(req_valid),
    .req_code(req_code), .req_bank(req_bank), .req_addr(req_addr), .req_term(req_term),
    .req_ready(req_ready), .pins(pins_if));
  sdcd_decoder i_sdcd_decoder (.mclk(mclk), .reset_n(reset_n), .pins(pins_if),
    .cmd_code(cmd_code), .cmd_valid(cmd_valid), .cmd_bank(cmd_bank), .cmd_addr(cmd_addr),
    .cmd_autoclose(cmd_autoclose), .cmd_chop(cmd_chop), .burst_busy(burst_busy),
    .pdown(pdown), .sref(sref), .refresh_act(refresh_act), .term_en(term_en));
  sdcd_props i_sdcd_props (.mclk(mclk), .reset_n(reset_n), .cs_n(pins_if.cs_n),
    .ras_n(pins_if.ras_n), .cas_n(pins_if.cas_n), .we_n(pins_if.we_n), .cke(pins_if.cke),
    .ba(pins_if.ba), .addr(pins_if.addr), .cmd_code(cmd_code), .cmd_valid(cmd_valid),
    .cmd_bank(cmd_bank), .cmd_addr(cmd_addr), .cmd_autoclose(cmd_autoclose),
    .cmd_chop(cmd_chop), .pdown(pdown), .sref(sref), .refresh_act(refresh_act),
    .term_en(term_en));
  ////////////////////////////////////////////////////////////////////////////
  // Free-running 8 ns clock
  always #4 mclk = ~mclk;
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // One request, answer seen two edges later
  task automatic send(input sdcd_row_t r, input logic term);
    repeat (6) @(negedge mclk);
    req_valid = 1'b1;
    req_code  = r.code;
    req_bank  = r.bank;
    req_addr  = r.addr;
    req_term  = term;
    @(negedge mclk);
    check(req_ready, 1'b1);
    req_valid = 1'b0;
    @(negedge mclk);
    check(cmd_code, r.code);
    check(cmd_valid, r.code != SDCD_DESELECT && r.code != SDCD_IDLE_CMD);
    if (r.chk[0]) begin
      check(cmd_bank, r.bank);
      check(cmd_addr[9:0], r.addr[9:0]);
    end
    if (r.chk[1]) begin
      check(cmd_autoclose, r.ac);
      check(cmd_chop, r.chop);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: table, then reset and refusal cases
  initial begin
    rows = '{'{SDCD_PD_EXIT, 3'h0, 15'h0000, 2'h0, 1'h0, 1'h0},
      '{SDCD_MODE_REG_WRITE, 3'h2, 15'h1234, 2'h1, 1'h0, 1'h0},
      '{SDCD_OPEN_ROW, 3'h5, 15'h7FFF, 2'h1, 1'h0, 1'h0},
      '{SDCD_STORE, 3'h1, 15'h1000, 2'h3, 1'h0, 1'h0},
      '{SDCD_STORE, 3'h3, 15'h0405, 2'h3, 1'h1, 1'h1},
      '{SDCD_READ, 3'h7, 15'h1402, 2'h3, 1'h1, 1'h0},
      '{SDCD_READ, 3'h0, 15'h0008, 2'h3, 1'h0, 1'h1},
      '{SDCD_CLOSE_BANK, 3'h4, 15'h0000, 2'h0, 1'h0, 1'h0},
      '{SDCD_CLOSE_ALL, 3'h0, 15'h0000, 2'h0, 1'h0, 1'h0},
      '{SDCD_ZQ_LONG, 3'h0, 15'h0000, 2'h0, 1'h0, 1'h0},
      '{SDCD_ZQ_SHORT, 3'h0, 15'h0000, 2'h0, 1'h0, 1'h0},
      '{SDCD_REFRESH, 3'h0, 15'h0000, 2'h0, 1'h0, 1'h0},
      '{SDCD_PD_ENTRY, 3'h0, 15'h0000, 2'h0, 1'h0, 1'h0},
      '{SDCD_PD_EXIT, 3'h0, 15'h0000, 2'h0, 1'h0, 1'h0},
      '{SDCD_SR_ENTRY, 3'h0, 15'h0000, 2'h0, 1'h0, 1'h0},
      '{SDCD_SR_EXIT, 3'h0, 15'h0000, 2'h0, 1'h0, 1'h0}};
    repeat (12) @(negedge mclk);
    reset_n = 1'b1;
    for (int i = 0; i < 16; i++) begin
      send(rows[i], i[0]);
      check(pdown, rows[i].code == SDCD_PD_ENTRY);
      check(refresh_act, rows[i].code != SDCD_PD_ENTRY);
      check(sref, rows[i].code == SDCD_SR_ENTRY);
      check(term_en, rows[i].code != SDCD_SR_ENTRY);
      check(burst_busy, rows[i].code == SDCD_STORE || rows[i].code == SDCD_READ);
    end
    // Reset taken between edges
    @(posedge mclk);
    #2 reset_n = 1'b0;
    #1 check(cmd_code, SDCD_DESELECT);
    repeat (12) @(negedge mclk);
    reset_n = 1'b1;
    // Read while clock enable low is refused
    req_valid = 1'b1;
    req_code  = SDCD_READ;
    @(negedge mclk);
    check(req_ready, 1'b0);
    check(pins_if.cas_n, 1'b1);
    req_valid = 1'b0;
    @(negedge mclk);
    check(req_ready, 1'b0);
    check(cmd_valid, 1'b0);
    send(rows[0], 1'b1);
    send(rows[5], 1'b0);
    // Fixed burst length once mode register zero is rewritten
    send('{SDCD_MODE_REG_WRITE, 3'h0, 15'h0000, 2'h1, 1'h0, 1'h0}, 1'b0);
    send('{SDCD_STORE, 3'h2, 15'h0400, 2'h3, 1'h1, 1'h0}, 1'b0);
    // Deselect is taken but reports no new command
    send('{SDCD_DESELECT, 3'h1, 15'h0000, 2'h0, 1'h0, 1'h0}, 1'b0);
    complete_run();
  end
  // Watchdog against a hang
  initial begin
    #(8 * 3000);
    num_errors++;
    complete_run();
  end
endmodule
